// ### hw/efr_pkg.sv
// Purpose: shared constants for the E1 framer pin block
// Assumes: core clock at 40 MHz
// Notes: one definition per figure
package efr_pkg;
    localparam int CORE_PERIOD_NS = 25;
    localparam int SYS4_PERIOD_NS = 244;
    localparam int SYS2_PERIOD_NS = 488;
    // Midpoint of the two system clock periods, in core cycles
    localparam int RATE_THRESH_CYC =
        ((SYS4_PERIOD_NS + SYS2_PERIOD_NS) / 2) / CORE_PERIOD_NS;
    localparam int FRAME_BITS = 256;
    localparam int SLOTS = 32;
    localparam int MF_FRAMES = 16;
    localparam int HALF_FRAME = 128;

    localparam logic [6:0] FAS_PATTERN = 7'h1b;
    localparam logic [7:0] TX_FAS_BYTE = 8'h9b;
    localparam logic [7:0] TX_NFAS_BYTE = 8'h5f;
    localparam logic [7:0] TX_MAS_BYTE = 8'h0b;
    localparam logic [7:0] IDLE_BYTE = 8'hd5;
    localparam logic [5:0] CRC_MFAS = 6'h0b;
    localparam logic [3:0] CRC_MFAS_FRAME = 4'hb;
    localparam logic [3:0] CRC_MFAS_LAST = 4'hc;
    localparam logic [4:0] SIG_SLOT = 5'h10;
    localparam logic [7:0] SIG_SLOT_LAST_BIT = 8'h87;

    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam int CTRL_8K_SEL_BIT = 0;
    localparam int CTRL_MF_SRC_BIT = 1;
    localparam int CTRL_SIG_SRC_BIT = 2;
    localparam int CTRL_NRZ_BIT = 3;
    localparam logic [7:0] CTRL_RESET = 8'h01;

    localparam int PIN_COUNT = 11;
    localparam int PIN_SYS_CLK = 0;
    localparam int PIN_LINE_CLK = 1;
    localparam int PIN_RX_A = 2;
    localparam int PIN_RX_B = 3;
    localparam int PIN_FRAME_N = 4;
    localparam int PIN_PAYLOAD = 5;
    localparam int PIN_SLOT_CTRL = 6;
    localparam int PIN_SIG_IN = 7;
    localparam int PIN_TX_MF = 8;
    localparam int PIN_ALARM_N = 9;
    localparam int PIN_PORT_TYPE = 10;
endpackage : efr_pkg

// ### hw/efr_pin_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to CORE_CLK
// Notes: level changes only when stages two and three agree
`timescale 1ns/100ps
module efr_pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic [WIDTH-1:0] PIN,
    output logic [WIDTH-1:0] LEVEL,
    output logic [WIDTH-1:0] RISE,
    output logic [WIDTH-1:0] FALL
);
    logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

    generate
        if (WIDTH < 1) begin : g_bad
            $error("efr_pin_sync needs WIDTH of at least one");
        end
    endgenerate

    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            lvl_q <= '0;
        end else begin
            s1_q <= PIN;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign LEVEL = lvl_q;
    assign RISE = lvl_d & ~lvl_q;
    assign FALL = ~lvl_d & lvl_q;
endmodule : efr_pin_sync

// ### hw/efr_framer.sv
// Purpose: E1 framer pin-level backplane and line datapath
// Assumes: framer pins asynchronous, register port on CORE_CLK; line clock well below CORE_CLK / 4
// Notes: AMI coding only, no slip control between the two frame sides
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
module efr_framer (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic SYSTEM_CLOCK_IN,
    input wire logic RECOVERED_LINE_CLOCK,
    input wire logic RX_RAIL_A,
    input wire logic RX_RAIL_B,
    input wire logic FRAME_PULSE_IN_N,
    input wire logic TX_PAYLOAD_STREAM_IN,
    input wire logic PER_SLOT_CONTROL_STREAM,
    input wire logic TX_SIGNALLING_STREAM_IN,
    input wire logic TX_MULTIFRAME_BOUNDARY_IN,
    input wire logic TX_ALARM_FORCE_N,
    input wire logic PORT_TYPE_SERIAL,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    output logic TX_RAIL_A,
    output logic TX_RAIL_B,
    output logic EXTRACTED_8K_OUT,
    output logic RX_PAYLOAD_STREAM_OUT,
    output logic RX_SIGNALLING_STREAM_OUT,
    output logic RX_MULTIFRAME_MARKER
);
    default clocking core_cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);

    logic [efr_pkg::PIN_COUNT-1:0] pins, lvl, rise, fall;

    // Active-low pins enter inverted, so the synchroniser resets to idle
    assign pins = {PORT_TYPE_SERIAL, ~TX_ALARM_FORCE_N,
        ~TX_MULTIFRAME_BOUNDARY_IN, TX_SIGNALLING_STREAM_IN,
        PER_SLOT_CONTROL_STREAM, TX_PAYLOAD_STREAM_IN, ~FRAME_PULSE_IN_N,
        RX_RAIL_B, RX_RAIL_A, RECOVERED_LINE_CLOCK, SYSTEM_CLOCK_IN};

    efr_pin_sync #(.WIDTH(efr_pkg::PIN_COUNT)) u_sync (
        .CORE_CLK(CORE_CLK),
        .RESET(RESET),
        .PIN(pins),
        .LEVEL(lvl),
        .RISE(rise),
        .FALL(fall)
    );

    wire sys_rise = rise[efr_pkg::PIN_SYS_CLK];
    wire ln_rise = rise[efr_pkg::PIN_LINE_CLK];
    wire ln_fall = fall[efr_pkg::PIN_LINE_CLK];
    wire rx_mark = lvl[efr_pkg::PIN_RX_A] | lvl[efr_pkg::PIN_RX_B];

    // Register port
    logic [7:0] ctrl_q, ctrl_d, rdata_q, rdata_d;
    logic is2m_q, is2m_d, aligned_q, aligned_d;
    logic [5:0] per_q, per_d;
    wire sel_8k = ctrl_q[efr_pkg::CTRL_8K_SEL_BIT];
    wire sel_mf = ctrl_q[efr_pkg::CTRL_MF_SRC_BIT];
    wire sel_sig = ctrl_q[efr_pkg::CTRL_SIG_SRC_BIT];
    wire sel_nrz = ctrl_q[efr_pkg::CTRL_NRZ_BIT];

    always_comb begin
        ctrl_d = (WR && ADDR == efr_pkg::ADDR_CTRL) ? WDATA : ctrl_q;
        rdata_d = 8'h00;
        if (RD && ADDR == efr_pkg::ADDR_CTRL) begin
            rdata_d = ctrl_q;
        end else if (RD && ADDR == efr_pkg::ADDR_STATUS) begin
            // Port type shown for the control-port selection
            rdata_d = {5'h00, lvl[efr_pkg::PIN_PORT_TYPE], aligned_q,
                is2m_q};
        end
        // Period of the system clock decides its rate
        per_d = (per_q == 6'h3f) ? per_q : per_q + 6'h01;
        is2m_d = is2m_q;
        if (sys_rise) begin
            per_d = 6'h00;
            is2m_d = (per_q >= 6'(efr_pkg::RATE_THRESH_CYC));
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            ctrl_q <= efr_pkg::CTRL_RESET;
            rdata_q <= 8'h00;
            per_q <= 6'h00;
            is2m_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
            per_q <= per_d;
            is2m_q <= is2m_d;
        end
    end

    // Backplane side
    logic [7:0] bp_cnt_q, bp_cnt_d, pay_sh_q, pay_sh_d, ctl_sh_q, ctl_sh_d;
    logic [7:0] sig_sh_q, sig_sh_d;
    logic phase_q, phase_d, pay_out_q, pay_out_d, sig_out_q, sig_out_d;
    logic mark_q, mark_d;
    logic [7:0] tx_buf_q [0:31];
    logic [7:0] tx_buf_d [0:31];
    logic [7:0] slot_ctl_q [0:31];
    logic [7:0] slot_ctl_d [0:31];
    logic [3:0] tx_sig_q [0:31];
    logic [3:0] tx_sig_d [0:31];
    logic [7:0] rx_buf_q [0:31];
    logic [3:0] rx_sig_q [0:31];
    logic [3:0] crc_frm_q, cas_frm_q;
    wire fp_low = lvl[efr_pkg::PIN_FRAME_N];
    // At 4.096 MHz every second rising edge carries a bit, counted
    // from the edge that sees the frame pulse
    wire bp_tick = sys_rise & (is2m_q | phase_q | fp_low);

    always_comb begin
        logic [7:0] rx_byte;
        rx_byte = 8'h00;
        bp_cnt_d = bp_cnt_q;
        phase_d = phase_q;
        pay_sh_d = pay_sh_q;
        ctl_sh_d = ctl_sh_q;
        sig_sh_d = sig_sh_q;
        pay_out_d = pay_out_q;
        sig_out_d = sig_out_q;
        mark_d = mark_q;
        tx_buf_d = tx_buf_q;
        slot_ctl_d = slot_ctl_q;
        tx_sig_d = tx_sig_q;
        if (sys_rise) begin
            phase_d = fp_low ? 1'b0 : ~phase_q;
        end
        if (bp_tick) begin
            // MSB first: bit 7 lands in sh[7]
            pay_sh_d = {pay_sh_q[6:0], lvl[efr_pkg::PIN_PAYLOAD]};
            ctl_sh_d = {ctl_sh_q[6:0], lvl[efr_pkg::PIN_SLOT_CTRL]};
            sig_sh_d = {sig_sh_q[6:0], lvl[efr_pkg::PIN_SIG_IN]};
            if (bp_cnt_q[2:0] == 3'h7) begin
                tx_buf_d[bp_cnt_q[7:3]] = pay_sh_d;
                slot_ctl_d[bp_cnt_q[7:3]] = ctl_sh_d;
                if (!sel_sig) begin
                    // Lower nibble dropped
                    tx_sig_d[bp_cnt_q[7:3]] = sig_sh_d[7:4];
                end
            end
            // Frame pulse restarts the count for every stream
            bp_cnt_d = fp_low ? 8'h00 : bp_cnt_q + 8'h01;
            rx_byte = rx_buf_q[bp_cnt_d[7:3]];
            pay_out_d = rx_byte[3'h7 - bp_cnt_d[2:0]];
            rx_byte = {rx_sig_q[bp_cnt_d[7:3]], rx_sig_q[bp_cnt_d[7:3]]};
            sig_out_d = rx_byte[3'h7 - bp_cnt_d[2:0]];
            if (fp_low) begin
                // Held one frame, decided per frame
                mark_d = sel_mf ? (crc_frm_q == 4'h0)
                                : (cas_frm_q == 4'h0);
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            bp_cnt_q <= 8'h00;
            phase_q <= 1'b0;
            pay_sh_q <= 8'h00;
            ctl_sh_q <= 8'h00;
            sig_sh_q <= 8'h00;
            pay_out_q <= 1'b1;
            sig_out_q <= 1'b1;
            mark_q <= 1'b0;
            for (int i = 0; i < efr_pkg::SLOTS; i++) begin
                tx_buf_q[i] <= 8'hff;
                slot_ctl_q[i] <= 8'h00;
                tx_sig_q[i] <= 4'hf;
            end
        end else begin
            bp_cnt_q <= bp_cnt_d;
            phase_q <= phase_d;
            pay_sh_q <= pay_sh_d;
            ctl_sh_q <= ctl_sh_d;
            sig_sh_q <= sig_sh_d;
            pay_out_q <= pay_out_d;
            sig_out_q <= sig_out_d;
            mark_q <= mark_d;
            tx_buf_q <= tx_buf_d;
            slot_ctl_q <= slot_ctl_d;
            tx_sig_q <= tx_sig_d;
        end
    end

    // Line receive
    logic [7:0] rx_cnt_q, rx_cnt_d, rx_sh_q, rx_sh_d;
    logic [5:0] crc_sh_q, crc_sh_d;
    logic [3:0] crc_frm_d, cas_frm_d;
    logic [7:0] rx_buf_d [0:31];
    logic [3:0] rx_sig_d [0:31];
    logic ext8k_q, ext8k_d;

    always_comb begin
        rx_cnt_d = rx_cnt_q;
        rx_sh_d = rx_sh_q;
        crc_sh_d = crc_sh_q;
        crc_frm_d = crc_frm_q;
        cas_frm_d = cas_frm_q;
        aligned_d = aligned_q;
        rx_buf_d = rx_buf_q;
        rx_sig_d = rx_sig_q;
        if (ln_rise) begin
            // Either rail carries a mark, RZ or NRZ
            rx_sh_d = {rx_sh_q[6:0], rx_mark};
            rx_cnt_d = rx_cnt_q + 8'h01;
            if (!aligned_q && rx_sh_d[6:0] == efr_pkg::FAS_PATTERN) begin
                rx_cnt_d = 8'h08;
                aligned_d = 1'b1;
                rx_buf_d[0] = rx_sh_d;
            end else if (rx_cnt_q[2:0] == 3'h7) begin
                rx_buf_d[rx_cnt_q[7:3]] = rx_sh_d;
            end
            if (rx_cnt_q == 8'h07 && rx_sh_d[6]) begin
                crc_sh_d = {crc_sh_q[4:0], rx_sh_d[7]};
                if (crc_sh_d == efr_pkg::CRC_MFAS) begin
                    crc_frm_d = efr_pkg::CRC_MFAS_FRAME;
                end
            end
            if (rx_cnt_q == efr_pkg::SIG_SLOT_LAST_BIT) begin
                if (rx_sh_d[7:4] == 4'h0) begin
                    cas_frm_d = 4'h0;
                end else if (cas_frm_q != 4'h0) begin
                    rx_sig_d[{1'b0, cas_frm_q}] = rx_sh_d[7:4];
                    rx_sig_d[{1'b1, cas_frm_q}] = rx_sh_d[3:0];
                end
            end
            if (rx_cnt_q == 8'hff) begin
                crc_frm_d = crc_frm_q + 4'h1;
                cas_frm_d = cas_frm_q + 4'h1;
            end
        end
        // Frame-aligned divide by 256
        ext8k_d = !sel_8k || (rx_cnt_q < 8'(efr_pkg::HALF_FRAME));
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            rx_cnt_q <= 8'h00;
            rx_sh_q <= 8'h00;
            crc_sh_q <= 6'h00;
            crc_frm_q <= 4'h1;
            cas_frm_q <= 4'h1;
            aligned_q <= 1'b0;
            ext8k_q <= 1'b1;
            for (int i = 0; i < efr_pkg::SLOTS; i++) begin
                rx_buf_q[i] <= 8'hff;
                rx_sig_q[i] <= 4'hf;
            end
        end else begin
            rx_cnt_q <= rx_cnt_d;
            rx_sh_q <= rx_sh_d;
            crc_sh_q <= crc_sh_d;
            crc_frm_q <= crc_frm_d;
            cas_frm_q <= cas_frm_d;
            aligned_q <= aligned_d;
            ext8k_q <= ext8k_d;
            rx_buf_q <= rx_buf_d;
            rx_sig_q <= rx_sig_d;
        end
    end

    // Line transmit
    logic [7:0] tx_cnt_q, tx_cnt_d, tx_byte;
    logic [3:0] tx_frm_q, tx_frm_d;
    logic mf_pend_q, mf_pend_d, pol_q, pol_d, rail_a_q, rail_a_d;
    logic rail_b_q, rail_b_d, tx_mark;
    wire [4:0] tx_slot = tx_cnt_q[7:3];

    always_comb begin
        tx_byte = tx_buf_q[tx_slot];
        if (slot_ctl_q[tx_slot][0]) begin
            tx_byte = efr_pkg::IDLE_BYTE;
        end
        if (tx_slot == 5'h00) begin
            tx_byte = efr_pkg::TX_NFAS_BYTE;
            if (!tx_frm_q[0]) begin
                tx_byte = efr_pkg::TX_FAS_BYTE;
            end else if (tx_frm_q < efr_pkg::CRC_MFAS_LAST) begin
                tx_byte[7] = efr_pkg::CRC_MFAS[3'h5 - tx_frm_q[3:1]];
            end
        end else if (tx_slot == efr_pkg::SIG_SLOT && !sel_sig) begin
            tx_byte = {tx_sig_q[{1'b0, tx_frm_q}],
                tx_sig_q[{1'b1, tx_frm_q}]};
            if (tx_frm_q == 4'h0) begin
                tx_byte = efr_pkg::TX_MAS_BYTE;
            end
        end
        // All ones while the alarm input is low
        tx_mark = tx_byte[3'h7 - tx_cnt_q[2:0]] | lvl[efr_pkg::PIN_ALARM_N];
        tx_cnt_d = tx_cnt_q;
        tx_frm_d = tx_frm_q;
        pol_d = pol_q;
        rail_a_d = rail_a_q;
        rail_b_d = rail_b_q;
        // New boundary survives a same-cycle frame end
        mf_pend_d = rise[efr_pkg::PIN_TX_MF] |
            (mf_pend_q & ~(ln_rise && tx_cnt_q == 8'hff));
        if (ln_rise) begin
            tx_cnt_d = tx_cnt_q + 8'h01;
            if (tx_cnt_q == 8'hff) begin
                // Free-running unless a boundary is pending
                tx_frm_d = mf_pend_q ? 4'h0 : tx_frm_q + 4'h1;
            end
            // Marks alternate between the two rails
            rail_a_d = tx_mark & ~pol_q;
            rail_b_d = tx_mark & pol_q;
            pol_d = pol_q ^ tx_mark;
        end else if (ln_fall && !sel_nrz) begin
            rail_a_d = 1'b0; // RZ returns to zero mid-bit
            rail_b_d = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            tx_cnt_q <= 8'h00;
            tx_frm_q <= 4'h0;
            mf_pend_q <= 1'b0;
            pol_q <= 1'b0;
            rail_a_q <= 1'b0;
            rail_b_q <= 1'b0;
        end else begin
            tx_cnt_q <= tx_cnt_d;
            tx_frm_q <= tx_frm_d;
            mf_pend_q <= mf_pend_d;
            pol_q <= pol_d;
            rail_a_q <= rail_a_d;
            rail_b_q <= rail_b_d;
        end
    end

    assign RDATA = rdata_q;
    assign TX_RAIL_A = rail_a_q;
    assign TX_RAIL_B = rail_b_q;
    assign EXTRACTED_8K_OUT = ext8k_q;
    assign RX_PAYLOAD_STREAM_OUT = pay_out_q;
    assign RX_SIGNALLING_STREAM_OUT = sig_out_q;
    assign RX_MULTIFRAME_MARKER = mark_q;

    a_rate_fast_clock: assert property (
        sys_rise && per_q < 6'(efr_pkg::RATE_THRESH_CYC) |=> !is2m_q)
        else $error("fast system clock not taken as 4.096 MHz");
    a_rx_rail_sample: assert property (
        ln_rise && aligned_q |=> rx_sh_q[0] == $past(rx_mark))
        else $error("receive rails not sampled on line rise");
    a_8k_half_frame: assert property (
        ln_rise && aligned_q && rx_cnt_q == 8'h7f && sel_8k
        |=> ##1 !EXTRACTED_8K_OUT)
        else $error("8 kHz output not low in second half");
    a_8k_forced_high: assert property (
        !sel_8k |=> EXTRACTED_8K_OUT)
        else $error("8 kHz output not high with select zero");
    a_marker_hold: assert property (
        $changed(RX_MULTIFRAME_MARKER) |-> $past(bp_tick && fp_low))
        else $error("multiframe marker changed inside a frame");
    a_alarm_all_ones: assert property (
        ln_rise && lvl[efr_pkg::PIN_ALARM_N] |=> TX_RAIL_A || TX_RAIL_B)
        else $error("alarm did not send a mark");
    a_rails_exclusive: assert property (
        !(TX_RAIL_A && TX_RAIL_B))
        else $error("both transmit rails high");
    a_rz_return: assert property (
        ln_fall && !ln_rise && !sel_nrz |=> !TX_RAIL_A && !TX_RAIL_B)
        else $error("RZ rails did not return to zero");
    a_mf_free_run: assert property (
        ln_rise && tx_cnt_q == 8'hff && tx_frm_q == 4'hf && !mf_pend_q
        |=> tx_frm_q == 4'h0 && tx_cnt_q == 8'h00)
        else $error("transmit multiframe did not wrap");
endmodule : efr_framer

// ### testbench/efr_far_end.sv
// Purpose: line transceiver and backplane source beside the framer
// Assumes: line clock free running; system clock rate chosen by bench
// Notes: line carries FAS/NFAS in slot 0, zeros elsewhere, AMI marks
`timescale 1ns/100ps
module efr_far_end (
    input wire logic slow_sys,
    output logic sys_clk,
    output logic line_clk,
    output logic rail_a,
    output logic rail_b,
    output logic frame_n,
    output logic payload
);
    logic [8:0] bit_n;
    logic [8:0] sys_cnt;
    logic [7:0] slot_byte;
    logic mark_b;
    logic one;

    initial begin
        sys_clk = 1'b0;
        line_clk = 1'b0;
        rail_a = 1'b0;
        rail_b = 1'b0;
        frame_n = 1'b1;
        payload = 1'b0;
        bit_n = 9'h000;
        sys_cnt = 9'h000;
        mark_b = 1'b0;
    end

    always begin
        #(slow_sys ? 244 : 122) sys_clk = ~sys_clk;
    end

    always begin
        #244 line_clk = ~line_clk;
    end

    // Backplane lines move on the falling edge, away from sampling
    always @(negedge sys_clk) begin
        sys_cnt <= sys_cnt + 9'h001;
        frame_n <= slow_sys ? (sys_cnt[7:0] != 8'hff)
                            : (sys_cnt != 9'h1ff);
        payload <= sys_cnt[3];
    end

    // Rails change at the fall so they stand still at the rise
    always @(negedge line_clk) begin
        slot_byte = (bit_n[7:3] != 5'h00) ? 8'h00 :
            (bit_n[8] ? 8'h5f : 8'h9b);
        one = slot_byte[3'h7 - bit_n[2:0]];
        rail_a <= one & ~mark_b;
        rail_b <= one & mark_b;
        if (one) begin
            mark_b <= ~mark_b;
        end
        bit_n <= bit_n + 9'h001;
    end
endmodule : efr_far_end

// ### testbench/tb.sv
// Purpose: self-checking bench for the framer pin block
// Assumes: register port one-cycle strobes, read data next cycle
// Notes: no slip control, so only the zero slots of the payload are compared
`timescale 1ns/100ps
module tb;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic sys_clk, line_clk, rx_a, rx_b, frame_n, payload;
    logic slow_sys = 1'b1;
    logic alarm_n = 1'b1;
    logic port_type = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic tx_a, tx_b, ext_8k, rx_pay, rx_sig, rx_mark;
    int failures = 0;
    int tests_run = 0;

    always #12.5 core_clk = ~core_clk;

    efr_far_end far (.slow_sys(slow_sys), .sys_clk(sys_clk),
        .line_clk(line_clk), .rail_a(rx_a), .rail_b(rx_b),
        .frame_n(frame_n), .payload(payload));

    // Boundary held high lets the transmit multiframe run free
    efr_framer DUT (.CORE_CLK(core_clk), .RESET(reset),
        .SYSTEM_CLOCK_IN(sys_clk), .RECOVERED_LINE_CLOCK(line_clk),
        .RX_RAIL_A(rx_a), .RX_RAIL_B(rx_b), .FRAME_PULSE_IN_N(frame_n),
        .TX_PAYLOAD_STREAM_IN(payload), .PER_SLOT_CONTROL_STREAM(1'b0),
        .TX_SIGNALLING_STREAM_IN(1'b1), .TX_MULTIFRAME_BOUNDARY_IN(1'b1),
        .TX_ALARM_FORCE_N(alarm_n), .PORT_TYPE_SERIAL(port_type),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .TX_RAIL_A(tx_a), .TX_RAIL_B(tx_b), .EXTRACTED_8K_OUT(ext_8k),
        .RX_PAYLOAD_STREAM_OUT(rx_pay), .RX_SIGNALLING_STREAM_OUT(rx_sig),
        .RX_MULTIFRAME_MARKER(rx_mark));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : reg_rd

    // Rails sampled at a set offset after a line clock rise
    task automatic line_bit(input int at_ns, output logic a, output logic b);
        @(posedge line_clk);
        #(at_ns);
        a = tx_a;
        b = tx_b;
    endtask : line_bit

    // Line slots 1 to 31 are zero; step is falling system clock edges per bit
    task automatic frame_check(input int step);
        logic m0;
        @(posedge frame_n);
        repeat (step - 1) @(negedge sys_clk);
        m0 = rx_mark;
        for (int i = 0; i < 256; i++) begin
            if (i >= 8) begin
                check(rx_pay, 1'b0);
            end
            check(rx_sig, 1'b1);
            check(rx_mark, m0);
            repeat (step) @(negedge sys_clk);
        end
    endtask : frame_check

    task automatic wait_8k(input logic lvl, output time t);
        int n;
        n = 0;
        while (ext_8k !== lvl && n < 8000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check(ext_8k, lvl);
        t = $time;
    endtask : wait_8k

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    initial begin
        // Roughly twice the expected length of the run
        #1500000;
        failures++;
        stop_test();
    end

    initial begin
        logic [7:0] d;
        logic [7:0] st;
        logic a0, b0, a1, b1;
        time t0, t1, t2;
        st = 8'h00;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1 check(ext_8k, 1'b1);
        check(rdata, 8'h00);
        reg_rd(efr_pkg::ADDR_CTRL, d);
        check(d, efr_pkg::CTRL_RESET);
        reg_rd(4'h8, d);
        check(d, 8'h00);
        reg_wr(efr_pkg::ADDR_CTRL, 8'h00);
        reg_rd(efr_pkg::ADDR_CTRL, d);
        check(d, 8'h00);
        for (int i = 0; i < 150; i++) begin
            #1000 check(ext_8k, 1'b1);
        end
        reg_wr(efr_pkg::ADDR_CTRL, 8'h01);
        for (int i = 0; i < 40 && st[1] !== 1'b1; i++) begin
            repeat (1000) @(posedge core_clk);
            reg_rd(efr_pkg::ADDR_STATUS, st);
        end
        check(st, 8'h03);
        wait_8k(1'b0, t0);
        wait_8k(1'b1, t0);
        wait_8k(1'b0, t1);
        wait_8k(1'b1, t2);
        check((t1 - t0 > 62400) && (t1 - t0 < 62600), 1'b1);
        check((t2 - t0 > 124900) && (t2 - t0 < 125100), 1'b1);
        frame_check(1);
        @(posedge core_clk);
        slow_sys <= 1'b0;
        port_type <= 1'b1;
        repeat (2000) @(posedge core_clk);
        reg_rd(efr_pkg::ADDR_STATUS, st);
        check(st, 8'h06);
        frame_check(2);
        reg_wr(efr_pkg::ADDR_STATUS, 8'hff);
        reg_wr(4'h8, 8'h0e);
        reg_rd(efr_pkg::ADDR_STATUS, st);
        check(st, 8'h06);
        reg_rd(efr_pkg::ADDR_CTRL, d);
        check(d, 8'h01);
        @(posedge core_clk);
        alarm_n <= 1'b0;
        repeat (4) line_bit(230, a0, b0);
        for (int i = 0; i < 16; i++) begin
            line_bit(230, a1, b1);
            check(a1 ^ b1, 1'b1);
            check(a1, b0);
            a0 = a1;
            b0 = b1;
        end
        line_bit(450, a1, b1);
        check({a1, b1}, 2'h0);
        reg_wr(efr_pkg::ADDR_CTRL, 8'h09);
        repeat (2) line_bit(450, a1, b1);
        check(a1 ^ b1, 1'b1);
        @(posedge core_clk);
        alarm_n <= 1'b1;
        for (int i = 0; i < 64; i++) begin
            line_bit(230, a1, b1);
            check(a1 & b1, 1'b0);
        end
        stop_test();
    end
endmodule : tb
